// *** src/lnb_pkg.sv ***
// constants, field layouts and types shared by the feed supply control block
// Summary of operation
// - answer one of four addresses from pin
// - register 0x00 is control on writes
// - read direction returns status after address
// - release data line on master nack
// - open-drain interrupt pulls low on fault
// - interrupt pulls low at supplies good
// - interrupt released only by read addressing
// - three faults latched, each raises interrupt
// - off and power-bad flags track, no interrupt
// - off flag follows feed disable or enable
// - latched faults hold until read completes
// - off flag clears when on, no fault
// - overcurrent clears: current low and read
// - power-bad follows feed voltage out of range
// - thermal clears: temperature normal and read
// - supply-low clears: supply good and read
// - control bits 2:0 level select, reset 000
// - top level bit picks low/high range
// - control bit 3 switches feed on
// - tone pin high gates 22kHz tone
// - status updates at ninth read clock rise
// - overcurrent held 5ms trips, disables feed
// - any latched fault disables feed, sets off
// - no acknowledge while supply below lockout
package lnb_pkg;
  localparam logic [6:0] SLAVE_BASE = 7'h08;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int LEVEL_MSB = 2;
  localparam int ON_BIT = 3;
  localparam int ST_OFF = 0;
  localparam int ST_OCP = 2;
  localparam int ST_PBAD = 4;
  localparam int ST_TSD = 6;
  localparam int ST_SUPPLY_LOW_FLAG = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int SYNC_W = 8;
  localparam int CLK_MHZ = 125;
  localparam int OCP_TIME_MS = 5;
  localparam int OCP_CYCLES = OCP_TIME_MS * CLK_MHZ * 1000;
  typedef enum logic [3:0] {
    IDLE, ADDR, AACK, REG, RACK, WDATA, WACK, TX, TXACK, TXLOAD, WAITP
  } i2c_state_t;
endpackage : lnb_pkg

// *** src/i2c_events_if.sv ***
// events derived from the sampled bus lines, passed from synchroniser to controller
`timescale 1ns/10ps
interface i2c_events_if;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaLevel;
  modport src (output sclRise, output sclFall, output startSeen, output stopSeen,
    output sdaLevel);
  modport dst (input sclRise, input sclFall, input startSeen, input stopSeen,
    input sdaLevel);
endinterface : i2c_events_if

// *** src/i2c_line_sync.sv ***
// two-stage synchroniser and edge / start / stop detection for the bus lines
`timescale 1ns/10ps
module i2c_line_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclPin,
  input wire logic sdaPin,
  i2c_events_if.src ev
);
  logic sclMeta_r, sclSync_r, sclLast_r;
  logic sdaMeta_r, sdaSync_r, sdaLast_r;

  // lines idle high, so reset to high avoids a false start after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sclLast_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaLast_r <= 1'b1;
    end else begin
      sclMeta_r <= sclPin;
      sclSync_r <= sclMeta_r;
      sclLast_r <= sclSync_r;
      sdaMeta_r <= sdaPin;
      sdaSync_r <= sdaMeta_r;
      sdaLast_r <= sdaSync_r;
    end
  end

  wire sclHigh = sclSync_r & sclLast_r;
  assign ev.sclRise = sclSync_r & ~sclLast_r;
  assign ev.sclFall = ~sclSync_r & sclLast_r;
  assign ev.startSeen = sclHigh & sdaLast_r & ~sdaSync_r;
  assign ev.stopSeen = sclHigh & ~sdaLast_r & sdaSync_r;
  assign ev.sdaLevel = sdaSync_r;

  property p_start_needs_scl_high;
    @(posedge clk) disable iff (!rst_n)
    ev.startSeen |-> sclSync_r && $past(sclSync_r) && $fell(sdaSync_r);
  endproperty
  a_start_needs_scl_high: assert property (p_start_needs_scl_high)
    else $error("start seen without scl high");
endmodule : i2c_line_sync

// *** src/fault_persist.sv ***
// persistence filter: trips once a condition has held for a set number of cycles
`timescale 1ns/10ps
module fault_persist #(
  parameter int HOLD_CYCLES = lnb_pkg::OCP_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cond,
  output logic tripped
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);
  logic [CW-1:0] cnt_r;
  logic tripped_r;

  // a short glitch restarts the count, so only a sustained overload trips
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tripped_r <= 1'b0;
    end else if (!cond) begin
      cnt_r <= '0;
      tripped_r <= 1'b0;
    end else if (cnt_r != LAST) begin
      cnt_r <= cnt_r + CW'(1);
      tripped_r <= 1'b0;
    end else begin
      tripped_r <= 1'b1;
    end
  end
  assign tripped = tripped_r;

  property p_trip_after_hold;
    @(posedge clk) disable iff (!rst_n)
    $rose(tripped_r) |-> $past(cond) && $past(cnt_r) == LAST;
  endproperty
  a_trip_after_hold: assert property (p_trip_after_hold)
    else $error("trip without full hold time");
endmodule : fault_persist

// *** src/lnb_supply_i2c_control_status.sv ***
// bus slave, control register, latched fault status and interrupt for the feed supply
`timescale 1ns/10ps
module lnb_supply_i2c_control_status #(
  parameter int OCP_CYCLES = lnb_pkg::OCP_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe_n,
  output logic irqOut,
  output logic irqOe_n,
  input wire logic [1:0] addrSelPin,
  input wire logic tone_gate_pin,
  input wire logic overCurrentPin,
  input wire logic thermalPin,
  input wire logic supplyLowPin,
  input wire logic logicSupplyOkPin,
  input wire logic feedVoltageBadPin,
  output logic [2:0] level_select,
  output logic range_select,
  output logic feed_output_on,
  output logic toneEnable,
  output logic [7:0] statusView
);
  // ---- pin synchronisers for the slow status and strap inputs
  logic [lnb_pkg::SYNC_W-1:0] pinMeta_r, pinSync_r;
  wire [lnb_pkg::SYNC_W-1:0] pinRaw = {addrSelPin, tone_gate_pin, overCurrentPin,
    thermalPin, supplyLowPin, logicSupplyOkPin, feedVoltageBadPin};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= pinRaw;
      pinSync_r <= pinMeta_r;
    end
  end

  wire [1:0] addrSelS = pinSync_r[7:6];
  wire toneS = pinSync_r[5];
  wire ocS = pinSync_r[4];
  wire thS = pinSync_r[3];
  wire ulS = pinSync_r[2];
  wire logicOkS = pinSync_r[1];
  wire feedBadS = pinSync_r[0];

  // ---- bus line events and overcurrent persistence
  i2c_events_if ev();

  i2c_line_sync u_line_sync (
    .clk(mclk),
    .rst_n(arst_n),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .ev(ev.src)
  );

  logic ocTrip;

  fault_persist #(.HOLD_CYCLES(OCP_CYCLES)) u_ocp_persist (
    .clk(mclk),
    .rst_n(arst_n),
    .cond(ocS),
    .tripped(ocTrip)
  );

  // ---- bus slave state
  lnb_pkg::i2c_state_t state_r, stateNxt;
  logic [3:0] cnt_r, cntNxt;
  logic [7:0] rx_r, rxNxt;
  logic [7:0] tx_r, txNxt;
  logic [7:0] ctrl_r, ctrlNxt;
  logic pull_r, pullNxt;
  logic readMode_r, readModeNxt;
  logic regOk_r, regOkNxt;
  logic readHit, readDone;

  // status flags
  logic ocpL_r, tsdL_r, uvloL_r;
  logic pbad_r, off_r, irqPend_r, powerUpDone_r, feedOn_r, tone_r;

  wire [6:0] slaveAddr = lnb_pkg::SLAVE_BASE | {5'h00, addrSelS};
  wire addrHit = rx_r[7:1] == slaveAddr;
  wire byteIn = ev.sclRise && cnt_r != lnb_pkg::BYTE_BITS;
  wire byteDone = ev.sclFall && cnt_r == lnb_pkg::BYTE_BITS;
  wire ackAllowed = ~ulS;
  wire anyLatched = ocpL_r | tsdL_r | uvloL_r;
  wire [7:0] statusByte = {uvloL_r, tsdL_r, 1'b0, pbad_r, 1'b0, ocpL_r, 1'b0, off_r};

  always_comb begin
    stateNxt = state_r;
    cntNxt = cnt_r;
    rxNxt = rx_r;
    txNxt = tx_r;
    ctrlNxt = ctrl_r;
    pullNxt = pull_r;
    readModeNxt = readMode_r;
    regOkNxt = regOk_r;
    readHit = 1'b0;
    readDone = 1'b0;
    if (ev.stopSeen) begin
      stateNxt = lnb_pkg::IDLE;
      pullNxt = 1'b0;
    end else if (ev.startSeen) begin
      stateNxt = lnb_pkg::ADDR;
      cntNxt = 4'h0;
      pullNxt = 1'b0;
    end else begin
      case (state_r)
        lnb_pkg::ADDR, lnb_pkg::REG, lnb_pkg::WDATA: begin
          if (byteIn) begin
            rxNxt = {rx_r[6:0], ev.sdaLevel};
            cntNxt = cnt_r + 4'h1;
          end else if (byteDone) begin
            cntNxt = 4'h0;
            stateNxt = lnb_pkg::WAITP;
            if (state_r == lnb_pkg::ADDR && addrHit && ackAllowed) begin
              pullNxt = 1'b1;
              readModeNxt = rx_r[0];
              readHit = rx_r[0];
              stateNxt = lnb_pkg::AACK;
            end else if (state_r == lnb_pkg::REG && ackAllowed) begin
              pullNxt = 1'b1;
              regOkNxt = rx_r == lnb_pkg::CTRL_ADDR;
              stateNxt = lnb_pkg::RACK;
            end else if (state_r == lnb_pkg::WDATA && ackAllowed) begin
              pullNxt = 1'b1;
              if (regOk_r) begin
                ctrlNxt = rx_r;
              end
              stateNxt = lnb_pkg::WACK;
            end
          end
        end
        lnb_pkg::AACK: begin
          if (ev.sclFall) begin
            if (readMode_r) begin
              txNxt = statusByte;
              pullNxt = ~statusByte[7];
              cntNxt = 4'h0;
              stateNxt = lnb_pkg::TX;
            end else begin
              pullNxt = 1'b0;
              stateNxt = lnb_pkg::REG;
            end
          end
        end
        lnb_pkg::RACK: begin
          if (ev.sclFall) begin
            pullNxt = 1'b0;
            stateNxt = lnb_pkg::WDATA;
          end
        end
        lnb_pkg::WACK: begin
          if (ev.sclFall) begin
            pullNxt = 1'b0;
            stateNxt = lnb_pkg::WAITP;
          end
        end
        lnb_pkg::TX: begin
          if (ev.sclRise) begin
            cntNxt = cnt_r + 4'h1;
          end else if (byteDone) begin
            pullNxt = 1'b0;
            stateNxt = lnb_pkg::TXACK;
          end else if (ev.sclFall) begin
            txNxt = {tx_r[6:0], 1'b0};
            pullNxt = ~tx_r[6];
          end
        end
        lnb_pkg::TXACK: begin
          if (ev.sclRise) begin
            readDone = 1'b1;
            stateNxt = ev.sdaLevel ? lnb_pkg::WAITP : lnb_pkg::TXLOAD;
          end
        end
        lnb_pkg::TXLOAD: begin
          if (ev.sclFall) begin
            txNxt = statusByte;
            pullNxt = ~statusByte[7];
            cntNxt = 4'h0;
            stateNxt = lnb_pkg::TX;
          end
        end
        lnb_pkg::IDLE, lnb_pkg::WAITP: begin
          pullNxt = 1'b0;
        end
        default: begin
          stateNxt = lnb_pkg::IDLE;
          pullNxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= lnb_pkg::IDLE;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      tx_r <= 8'h00;
      ctrl_r <= lnb_pkg::CTRL_RESET;
      pull_r <= 1'b0;
      readMode_r <= 1'b0;
      regOk_r <= 1'b0;
    end else begin
      state_r <= stateNxt;
      cnt_r <= cntNxt;
      rx_r <= rxNxt;
      tx_r <= txNxt;
      ctrl_r <= ctrlNxt;
      pull_r <= pullNxt;
      readMode_r <= readModeNxt;
      regOk_r <= regOkNxt;
    end
  end

  // ---- latched faults: a new trip wins over a clear in the same cycle
  wire suppliesOk = ~ulS & logicOkS;
  wire powerUpEv = suppliesOk & ~powerUpDone_r;
  wire newFault = (ocTrip & ~ocpL_r) | (thS & ~tsdL_r) | (ulS & ~uvloL_r);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ocpL_r <= 1'b0;
      tsdL_r <= 1'b0;
      uvloL_r <= 1'b0;
    end else begin
      ocpL_r <= ocTrip | (ocpL_r & ~(readDone & ~ocS));
      tsdL_r <= thS | (tsdL_r & ~(readDone & ~thS));
      uvloL_r <= ulS | (uvloL_r & ~(readDone & ~ulS));
    end
  end

  // ---- tracking flags, feed control and interrupt
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pbad_r <= 1'b0;
      off_r <= 1'b0;
      feedOn_r <= 1'b0;
      tone_r <= 1'b0;
      irqPend_r <= 1'b0;
      powerUpDone_r <= 1'b0;
    end else begin
      pbad_r <= feedBadS;
      off_r <= ~ctrl_r[lnb_pkg::ON_BIT] | anyLatched | ulS;
      feedOn_r <= ctrl_r[lnb_pkg::ON_BIT] & ~anyLatched & ~ulS & ~ocTrip;
      tone_r <= toneS;
      powerUpDone_r <= powerUpDone_r | suppliesOk;
      irqPend_r <= newFault | powerUpEv | (irqPend_r & ~readHit);
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe_n = ~pull_r;
  assign irqOut = 1'b0;
  assign irqOe_n = ~irqPend_r;
  assign level_select = ctrl_r[lnb_pkg::LEVEL_MSB:0];
  assign range_select = ctrl_r[lnb_pkg::LEVEL_MSB];
  assign feed_output_on = feedOn_r;
  assign toneEnable = tone_r;
  assign statusView = statusByte;

  // ---- checks
  property p_ack_only_on_match;
    @(posedge mclk) disable iff (!arst_n)
    $rose(pull_r) && stateNxt == lnb_pkg::AACK |-> rx_r[7:1] == slaveAddr;
  endproperty
  a_ack_only_on_match: assert property (p_ack_only_on_match)
    else $error("address ack without match");

  property p_no_ack_in_lockout;
    @(posedge mclk) disable iff (!arst_n)
    byteDone && ulS && !ev.stopSeen && !ev.startSeen && state_r != lnb_pkg::TX
      |=> sdaOe_n;
  endproperty
  a_no_ack_in_lockout: assert property (p_no_ack_in_lockout)
    else $error("ack given during supply lockout");

  property p_fault_raises_irq;
    @(posedge mclk) disable iff (!arst_n)
    $rose(ocpL_r) || $rose(tsdL_r) || $rose(uvloL_r) |-> !irqOe_n;
  endproperty
  a_fault_raises_irq: assert property (p_fault_raises_irq)
    else $error("latched fault without interrupt");

  property p_irq_release_by_read;
    @(posedge mclk) disable iff (!arst_n)
    $rose(irqOe_n) |-> $past(readHit);
  endproperty
  a_irq_release_by_read: assert property (p_irq_release_by_read)
    else $error("interrupt released without read addressing");

  property p_latch_hold;
    @(posedge mclk) disable iff (!arst_n)
    $fell(ocpL_r) || $fell(tsdL_r) || $fell(uvloL_r) |-> $past(readDone);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched fault cleared without completed read");

  property p_nack_releases;
    @(posedge mclk) disable iff (!arst_n)
    state_r == lnb_pkg::TXACK && ev.sclRise && ev.sdaLevel |=> sdaOe_n [*2];
  endproperty
  a_nack_releases: assert property (p_nack_releases)
    else $error("data line driven after master nack");

  property p_fault_disables_feed;
    @(posedge mclk) disable iff (!arst_n)
    anyLatched |=> !feed_output_on && statusByte[lnb_pkg::ST_OFF];
  endproperty
  a_fault_disables_feed: assert property (p_fault_disables_feed)
    else $error("feed on while fault latched");

  property p_unused_zero;
    @(posedge mclk) disable iff (!arst_n)
    statusByte[1] == 1'b0 && statusByte[3] == 1'b0 && statusByte[5] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused status bit set");

  property p_write_commits;
    @(posedge mclk) disable iff (!arst_n)
    state_r == lnb_pkg::WDATA && byteDone && regOk_r && ackAllowed && !ev.stopSeen
      && !ev.startSeen |=> ctrl_r == $past(rx_r) ##1 feed_output_on == (ctrl_r[3]
      && !anyLatched && !ulS && !ocTrip) || anyLatched;
  endproperty
  a_write_commits: assert property (p_write_commits)
    else $error("control write not taken");
endmodule : lnb_supply_i2c_control_status

// *** sim/i2c_host_model.sv ***
// bus master model: drives the bus clock and pulls the data line low through an open-drain stage
`timescale 1ns/10ps
module i2c_host_model (
  output logic sclOut,
  output logic sdaLow,
  input wire logic sdaIn
);
  logic q;

  // quarter-bit timebase, offset so that no bus edge lands on a system clock edge
  initial begin
    q = 1'b0;
    sclOut = 1'b1;
    sdaLow = 1'b0;
    #1.3;
    forever #31.25 q = ~q;
  end

  // one bit: data changes in the low phase, sampled in the middle of the high phase
  task automatic clk_bit(input logic drv, output logic seen);
    @(q);
    sdaLow = ~drv;
    @(q);
    sclOut = 1'b1;
    @(q);
    seen = sdaIn;
    @(q);
    sclOut = 1'b0;
  endtask : clk_bit

  task automatic start();
    if (!sclOut) begin
      @(q);
      sdaLow = 1'b0;
      @(q);
      sclOut = 1'b1;
    end
    @(q);
    sdaLow = 1'b1;
    @(q);
    sclOut = 1'b0;
  endtask : start

  task automatic stop();
    @(q);
    sdaLow = 1'b1;
    @(q);
    sclOut = 1'b1;
    @(q);
    sdaLow = 1'b0;
    @(q);
  endtask : stop

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : write_byte

  // cont low gives the closing not-acknowledge
  task automatic read_byte(input logic cont, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(~cont, s);
  endtask : read_byte
endmodule : i2c_host_model

// *** sim/tb_top.sv ***
// bench: host model, design, reference model of control and status, scenarios
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] addrSel = 2'h0;
  logic [2:0] flt = 3'h0;
  logic tone = 1'b0;
  logic feedBad = 1'b0;
  logic scl, hostLow, sdaOut, sdaOe_n, irqOut, irqOe_n, rangeSel, feedOn, toneEn;
  logic [2:0] lvl;
  logic [7:0] stView;
  logic [7:0] mCtrl = 8'h00;
  logic [2:0] mLat = 3'h0;
  logic mIrq = 1'b0;
  logic logicOk = 1'b0;
  int errTotal = 0;
  int samplesChecked = 0;
  // pull-ups on both shared lines
  wire logic sdaBus = hostLow ? 1'b0 : (!sdaOe_n ? sdaOut : 1'b1);
  wire logic irqLine = !irqOe_n ? irqOut : 1'b1;

  always #4 mclk = ~mclk;

  i2c_host_model i_host (.sclOut(scl), .sdaLow(hostLow), .sdaIn(sdaBus));

  lnb_supply_i2c_control_status #(.OCP_CYCLES(20)) i_dut (
    .mclk(mclk), .arst_n(arst_n), .sclPin(scl), .sdaPin(sdaBus), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .irqOut(irqOut), .irqOe_n(irqOe_n), .addrSelPin(addrSel),
    .tone_gate_pin(tone), .overCurrentPin(flt[2]), .thermalPin(flt[0]),
    .supplyLowPin(flt[1]), .logicSupplyOkPin(logicOk), .feedVoltageBadPin(feedBad),
    .level_select(lvl), .range_select(rangeSel), .feed_output_on(feedOn),
    .toneEnable(toneEn), .statusView(stView));

  function automatic logic [7:0] expStatus();
    logic off;
    off = !mCtrl[3] || (mLat != 3'h0);
    return {mLat[1], mLat[0], 1'b0, feedBad, 1'b0, mLat[2], 1'b0, off};
  endfunction : expStatus

  function automatic logic [6:0] devAddr();
    return 7'h08 | {5'h0, addrSel};
  endfunction : devAddr

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tallyAndFinish

  task automatic checkOut();
    // two sync stages plus the output register: settled at the fourth falling edge
    repeat (4) @(negedge mclk);
    check(stView, expStatus());
    check({7'h0, irqLine}, {7'h0, !mIrq});
    check({7'h0, feedOn}, {7'h0, mCtrl[3] && mLat == 3'h0});
    check({4'h0, rangeSel, lvl}, {4'h0, mCtrl[2], mCtrl[2:0]});
  endtask : checkOut

  task automatic wr(input logic [6:0] a7, input logic [7:0] r, input logic [7:0] d);
    logic k;
    i_host.start();
    i_host.write_byte({a7, 1'b0}, k);
    check({7'h0, k}, {7'h0, a7 == devAddr() && !flt[1]});
    if (k) begin
      // address, register and data bytes only
      i_host.write_byte(r, k);
      check({7'h0, k}, 8'h01);
      i_host.write_byte(d, k);
      check({7'h0, k}, 8'h01);
      if (r == 8'h00) begin
        mCtrl = d;
      end
    end
    i_host.stop();
    checkOut();
  endtask : wr

  task automatic rd(input int n);
    logic a;
    logic [7:0] d;
    logic [7:0] e;
    i_host.start();
    i_host.write_byte({devAddr(), 1'b1}, a);
    check({7'h0, a}, {7'h0, !flt[1]});
    if (a) begin
      mIrq = 1'b0;
      for (int i = 0; i < n; i++) begin
        e = expStatus();
        i_host.read_byte(i < n - 1, d);
        check(d, e);
        // latched bits drop only where their condition has gone
        mLat = mLat & flt;
      end
      repeat (5) @(negedge mclk);
      check({7'h0, sdaOe_n}, 8'h01);
    end
    i_host.stop();
    checkOut();
  endtask : rd

  initial begin
    #400000;
    errTotal++;
    tallyAndFinish();
  end

  initial begin
    void'($urandom(19));
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    // logic supply not yet good: no power-up request
    checkOut();
    @(posedge mclk);
    logicOk <= 1'b1;
    mIrq = 1'b1;
    checkOut();
    rd(1);
    for (int c = 0; c < 4; c++) begin
      @(posedge mclk);
      addrSel <= 2'(c);
      for (int a = 8; a < 12; a++) begin
        wr(7'(a), 8'h00, {4'h0, 4'($urandom)});
      end
    end
    wr(devAddr(), 8'h01, 8'h07);
    wr(devAddr(), 8'h00, 8'h0d);
    repeat (4) begin
      @(posedge mclk);
      tone <= 1'($urandom);
      repeat (5) @(negedge mclk);
      check({7'h0, toneEn}, {7'h0, tone});
    end
    repeat (4) begin
      @(posedge mclk);
      feedBad <= 1'($urandom);
      checkOut();
      rd(1);
    end
    // short overload: below the trip time, nothing latches
    @(posedge mclk);
    flt[2] <= 1'b1;
    repeat (12) @(posedge mclk);
    flt[2] <= 1'b0;
    checkOut();
    for (int f = 0; f < 3; f++) begin
      @(posedge mclk);
      flt[f] <= 1'b1;
      repeat (30) @(posedge mclk);
      mLat[f] = 1'b1;
      mIrq = 1'b1;
      checkOut();
      rd(1);
      @(posedge mclk);
      flt[f] <= 1'b0;
      checkOut();
      rd(2);
    end
    rd(3);
    tallyAndFinish();
  end
endmodule : tb_top
